/* File: core/bawp_match.sv */
`timescale 1ns/1ps
`default_nettype none
module bawp_match
    import bawp_pkg::*;
#(
    parameter bit IS_ZERO = 1'b0
) (
    input wire logic [31:0] low,
    input wire logic [31:0] high,
    input wire logic [31:0] ctl,
    input wire logic txn_valid,
    input wire logic [31:0] txn_addr,
    input wire logic txn_write,
    input wire logic [2:0] txn_master,
    input wire logic txn_fetch,
    input wire logic txn_done,
    input wire logic txn_abort,
    output logic hit
);
    function automatic logic bawp_is_ext(input logic [31:0] a);
        return a >= BAWP_EXT_BASE;
    endfunction

    logic [1:0] mode;
    logic in_block, unlimited, blk_ok, addr_ok, mst_ok, dir_ok, core_ok, dma_ext;
    logic below, above;

    always_comb begin
        mode = ctl[BAWP_MODE_LSB +: 2];
        below = txn_addr < low;
        above = txn_addr > high;
        // region of the transaction must be the region of the low bound
        in_block = (bawp_is_ext(txn_addr) == bawp_is_ext(low)) && (bawp_is_ext(low)
            || txn_addr[BAWP_BLK_MSB:BAWP_BLK_LSB] == low[BAWP_BLK_MSB:BAWP_BLK_LSB]);
        unlimited = IS_ZERO && txn_fetch && (txn_master == BAWP_MST_SEQ);
        blk_ok = in_block || unlimited;
        unique case (mode)
            BAWP_MODE_SINGLE: addr_ok = txn_addr == low;
            BAWP_MODE_RANGE: addr_ok = blk_ok && !below && !above;
            BAWP_MODE_OUTSIDE: addr_ok = blk_ok && (below || above);
            default: addr_ok = 1'b0;
        endcase
        if (IS_ZERO && ctl[BAWP_COMB_BIT]) begin
            addr_ok = 1'b1;
        end
        mst_ok = (txn_master <= BAWP_MST_LINK) && ctl[BAWP_MASTER_LSB + txn_master];
        dir_ok = txn_write ? ctl[BAWP_WR_BIT] : ctl[BAWP_RD_BIT];
        core_ok = (txn_master > BAWP_MST_KIALU) || (txn_done && !txn_abort);
        dma_ext = (txn_master == BAWP_MST_DMA) && bawp_is_ext(low)
            && bawp_is_ext(txn_addr);
        hit = txn_valid && (mode != BAWP_MODE_OFF) && addr_ok && mst_ok && dir_ok
            && core_ok && !dma_ext;
    end
endmodule
`default_nettype wire

/* File: core/bawp_pkg.sv */
package bawp_pkg;
    localparam int BAWP_SETS = 3;
    // register map: one 16-byte window per watchpoint set
    localparam logic [7:0] BAWP_OFS_LOW = 8'h00;
    localparam logic [7:0] BAWP_OFS_HIGH = 8'h04;
    localparam logic [7:0] BAWP_OFS_CTL = 8'h08;
    localparam logic [7:0] BAWP_OFS_STAT = 8'h0C;
    localparam logic [7:0] BAWP_SET_STRIDE = 8'h10;
    localparam logic [31:0] BAWP_RST_WORD = 32'h0000_0000;
    // control field positions
    localparam int BAWP_MODE_LSB = 0;
    localparam int BAWP_MASTER_LSB = 2;
    localparam int BAWP_MASTER_W = 6;
    localparam int BAWP_RD_BIT = 8;
    localparam int BAWP_WR_BIT = 9;
    localparam int BAWP_ACT_LSB = 10;
    localparam int BAWP_COMB_BIT = 12;
    localparam int BAWP_COUNT_LSB = 16;
    localparam int BAWP_EXEC_LSB = 16;
    // match modes
    localparam logic [1:0] BAWP_MODE_OFF = 2'h0;
    localparam logic [1:0] BAWP_MODE_SINGLE = 2'h1;
    localparam logic [1:0] BAWP_MODE_RANGE = 2'h2;
    localparam logic [1:0] BAWP_MODE_OUTSIDE = 2'h3;
    // execution state shown in status
    localparam logic [1:0] BAWP_EXEC_IDLE = 2'h0;
    localparam logic [1:0] BAWP_EXEC_SEARCH = 2'h1;
    localparam logic [1:0] BAWP_EXEC_EXPIRED = 2'h3;
    // expiry actions
    localparam logic [1:0] BAWP_ACT_PIN = 2'h0;
    localparam logic [1:0] BAWP_ACT_SWEXC = 2'h1;
    localparam logic [1:0] BAWP_ACT_TRAP = 2'h2;
    // bus master identities, one master_select bit each
    localparam logic [2:0] BAWP_MST_SEQ = 3'h0;
    localparam logic [2:0] BAWP_MST_JIALU = 3'h1;
    localparam logic [2:0] BAWP_MST_KIALU = 3'h2;
    localparam logic [2:0] BAWP_MST_DMA = 3'h3;
    localparam logic [2:0] BAWP_MST_HOST = 3'h4;
    localparam logic [2:0] BAWP_MST_LINK = 3'h5;
    // memory map: external space from this base, internal blocks by index bits
    localparam logic [31:0] BAWP_EXT_BASE = 32'h1000_0000;
    localparam int BAWP_BLK_LSB = 16;
    localparam int BAWP_BLK_MSB = 21;
    // AHB
    localparam logic [1:0] BAWP_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] BAWP_HRESP_OKAY = 2'h0;
endpackage

/* File: core/bawp_top.sv */
`timescale 1ns/1ps
`default_nettype none
module bawp_top
    import bawp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic [1:0] hresp,
    input wire logic txn_valid,
    input wire logic [31:0] txn_addr,
    input wire logic txn_write,
    input wire logic [2:0] txn_master,
    input wire logic txn_fetch,
    input wire logic txn_done,
    input wire logic txn_abort,
    output logic sw_exception,
    output logic emu_trap,
    output logic emulation_indication_pin
);
    typedef struct packed {
        logic [BAWP_SETS-1:0][31:0] low;
        logic [BAWP_SETS-1:0][31:0] high;
        logic [BAWP_SETS-1:0][31:0] ctl;
        logic [BAWP_SETS-1:0][15:0] cnt;
        logic [BAWP_SETS-1:0][1:0] exec;
        logic dph;
        logic dph_wr;
        logic [7:0] dph_addr;
        logic ready;
        logic [31:0] rdata;
        logic sw_exc;
        logic trap;
        logic pin;
    } bawp_state_type;

    bawp_state_type st, next_st;
    logic [BAWP_SETS-1:0] hit;
    logic [BAWP_SETS-1:0] dec;
    logic [BAWP_SETS-1:0] ctl_wr;

    function automatic logic [1:0] bawp_set_of(input logic [7:0] a);
        return a[5:4];
    endfunction

    function automatic logic bawp_mapped(input logic [7:0] a);
        return (a[7:6] == 2'h0) && (a[5:4] < 2'(BAWP_SETS));
    endfunction

    // one matcher per set, all watching the same bus concurrently
    for (genvar g = 0; g < BAWP_SETS; g++) begin : g_set
        bawp_match #(
            .IS_ZERO(g == 0)
        ) u_match (
            .low(st.low[g]),
            .high(st.high[g]),
            .ctl(st.ctl[g]),
            .txn_valid(txn_valid),
            .txn_addr(txn_addr),
            .txn_write(txn_write),
            .txn_master(txn_master),
            .txn_fetch(txn_fetch),
            .txn_done(txn_done),
            .txn_abort(txn_abort),
            .hit(hit[g])
        );
    end

    always_comb begin
        logic [1:0] ws;
        logic [1:0] rs;
        logic [15:0] init;
        next_st = st;
        ws = bawp_set_of(st.dph_addr);
        rs = bawp_set_of(haddr[7:0]);
        init = 16'h0000;
        next_st.sw_exc = 1'b0;
        next_st.trap = 1'b0;
        next_st.pin = 1'b0;
        next_st.ready = 1'b1;
        // address phase capture; zero wait states
        next_st.dph = hsel && (htrans == BAWP_HTRANS_NONSEQ) && hready;
        if (next_st.dph) begin
            next_st.dph_wr = hwrite;
            next_st.dph_addr = haddr[7:0];
        end
        ctl_wr = '0;
        if (st.dph && st.dph_wr && bawp_mapped(st.dph_addr)
                && (st.dph_addr[3:0] == BAWP_OFS_CTL[3:0])) begin
            ctl_wr[ws] = 1'b1;
        end
        // combining only on sets one and two
        dec[0] = hit[0];
        dec[1] = st.ctl[1][BAWP_COMB_BIT] ? |hit : hit[1];
        dec[2] = st.ctl[2][BAWP_COMB_BIT] ? &hit : hit[2];
        for (int i = 0; i < BAWP_SETS; i++) begin
            if (st.exec[i] == BAWP_EXEC_SEARCH && dec[i]) begin
                next_st.cnt[i] = st.cnt[i] - 16'h0001;
                if (st.cnt[i] == 16'h0001) begin
                    next_st.exec[i] = BAWP_EXEC_EXPIRED;
                    unique case (st.ctl[i][BAWP_ACT_LSB +: 2])
                        BAWP_ACT_SWEXC: next_st.sw_exc = 1'b1;
                        BAWP_ACT_TRAP: next_st.trap = 1'b1;
                        default: next_st.pin = 1'b1;
                    endcase
                end
            end
        end
        // register writes in the data phase; a control write restarts the set
        if (st.dph && st.dph_wr && bawp_mapped(st.dph_addr)) begin
            unique case (st.dph_addr[3:0])
                BAWP_OFS_LOW[3:0]: next_st.low[ws] = hwdata;
                BAWP_OFS_HIGH[3:0]: next_st.high[ws] = hwdata;
                BAWP_OFS_CTL[3:0]: begin
                    init = hwdata[BAWP_COUNT_LSB +: 16];
                    next_st.ctl[ws] = {hwdata[31:13] & 19'h7FFF8, hwdata[12:0]};
                    next_st.cnt[ws] = init;
                    // zero count cannot expire, so it does not start
                    if (hwdata[BAWP_MODE_LSB +: 2] != BAWP_MODE_OFF && init != 16'h0000) begin
                        next_st.exec[ws] = BAWP_EXEC_SEARCH;
                    end else begin
                        next_st.exec[ws] = BAWP_EXEC_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end
        // read data taken from the updated copy so a write is seen at once
        next_st.rdata = 32'h0000_0000;
        if (next_st.dph && !hwrite && bawp_mapped(haddr[7:0])) begin
            unique case (haddr[3:0])
                BAWP_OFS_LOW[3:0]: next_st.rdata = next_st.low[rs];
                BAWP_OFS_HIGH[3:0]: next_st.rdata = next_st.high[rs];
                BAWP_OFS_CTL[3:0]: next_st.rdata = next_st.ctl[rs];
                default: next_st.rdata = {14'h0000, next_st.exec[rs], next_st.cnt[rs]};
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign hreadyout = st.ready;
    assign hrdata = st.rdata;
    assign hresp = BAWP_HRESP_OKAY;
    assign sw_exception = st.sw_exc;
    assign emu_trap = st.trap;
    assign emulation_indication_pin = st.pin;

    AST_LOAD_COUNT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctl_wr[0] |=> st.cnt[0] == $past(hwdata[31:16]))
        else $error("control write did not load the counter");

    AST_START: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ctl_wr[1] && hwdata[1:0] != 2'h0 && hwdata[31:16] != 16'h0000)
        |=> st.exec[1] == BAWP_EXEC_SEARCH)
        else $error("non-idle mode did not start the search");

    AST_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ctl_wr[2] && hwdata[1:0] == 2'h0) |=> st.exec[2] == BAWP_EXEC_IDLE)
        else $error("disabled mode left the set running");

    AST_DECREMENT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st.exec[0] == BAWP_EXEC_SEARCH && hit[0] && !ctl_wr[0])
        |=> st.cnt[0] == $past(st.cnt[0]) - 16'h0001)
        else $error("match did not decrement the counter");

    AST_OR_COMBINE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st.exec[1] == BAWP_EXEC_SEARCH && st.ctl[1][12] && hit[2] && !ctl_wr[1])
        |=> st.cnt[1] == $past(st.cnt[1]) - 16'h0001)
        else $error("or combine missed another set's match");

    AST_AND_COMBINE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st.ctl[2][12] && !(&hit) && !ctl_wr[2]) |=> $stable(st.cnt[2]))
        else $error("and combine counted a partial match");

    AST_EXPIRE_ACTION: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st.exec[0] == BAWP_EXEC_SEARCH && hit[0] && st.cnt[0] == 16'h0001
        && !ctl_wr[0] && st.ctl[0][11:10] == 2'h1)
        |=> st.exec[0] == BAWP_EXEC_EXPIRED && sw_exception)
        else $error("expiry did not raise the software exception");

    AST_ABORT_NO_HIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (txn_abort && txn_master <= BAWP_MST_KIALU) |-> hit == '0)
        else $error("aborted core transaction matched");

    AST_PIN_ONLY: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st.exec[2] == BAWP_EXEC_SEARCH && dec[2] && st.cnt[2] == 16'h0001
        && !ctl_wr[2] && st.ctl[2][11:10] == 2'h0) |=> emulation_indication_pin)
        else $error("pin only expiry did not pulse the indication pin");

    AST_NO_REARM: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st.exec[1] == BAWP_EXEC_EXPIRED && !ctl_wr[1])
        |=> st.exec[1] == BAWP_EXEC_EXPIRED && st.cnt[1] == 16'h0000)
        else $error("expired watchpoint rearmed itself");

    AST_STATUS_READ: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (hsel && htrans == 2'h2 && hready && !hwrite && haddr[7:0] == 8'h0C)
        |=> hrdata[17:16] == st.exec[0] && hrdata[15:0] == st.cnt[0])
        else $error("status read does not show counter and state");
endmodule
`default_nettype wire

/* File: tb/bawp_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bawp_bus_model (
    input wire logic clk_sys,
    input wire logic req,
    input wire logic [31:0] req_addr,
    input wire logic req_write,
    input wire logic [2:0] req_master,
    input wire logic req_fetch,
    input wire logic req_abort,
    output logic txn_valid,
    output logic [31:0] txn_addr,
    output logic txn_write,
    output logic [2:0] txn_master,
    output logic txn_fetch,
    output logic txn_done,
    output logic txn_abort
);
    localparam logic [2:0] BAWP_MST_KIALU_M = 3'h2;
    initial begin
        txn_valid = 1'b0;
        txn_addr = 32'h0;
        txn_write = 1'b0;
        txn_master = 3'h0;
        txn_fetch = 1'b0;
        txn_done = 1'b0;
        txn_abort = 1'b0;
    end
    // an idle bus shows inverted leftovers, flipping back to the last transaction on every second idle cycle
    always @(posedge clk_sys) begin
        txn_valid <= req;
        txn_addr <= req ? req_addr : ~txn_addr;
        txn_write <= req ? req_write : ~txn_write;
        txn_master <= req ? req_master : ~txn_master;
        txn_fetch <= req & req_fetch;
        txn_done <= req & (req_master <= BAWP_MST_KIALU_M) & ~req_abort;
        txn_abort <= req & req_abort;
    end
endmodule
`default_nettype wire

/* File: tb/bus_address_watchpoints_test.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_address_watchpoints_test
    import bawp_pkg::*;
;
    logic clk_sys, rst_n, hsel, hwrite, hreadyout, req, req_write, req_fetch, req_abort;
    logic [31:0] haddr, hwdata, hrdata, req_addr, txn_addr;
    logic [1:0] htrans, hresp;
    logic [2:0] req_master, txn_master;
    logic txn_valid, txn_write, txn_fetch, txn_done, txn_abort;
    logic sw_exception, emu_trap, emulation_indication_pin;
    int n_fail = 0;
    int n_tests = 0;
    int cycles = 0;
    localparam logic [5:0] M_SEQ = 6'h01 << BAWP_MST_SEQ;
    localparam logic [5:0] M_J = 6'h01 << BAWP_MST_JIALU;
    localparam logic [5:0] M_DMA = 6'h01 << BAWP_MST_DMA;
    localparam logic [5:0] M_HOST = 6'h01 << BAWP_MST_HOST;

    bawp_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .txn_valid(txn_valid),
        .txn_addr(txn_addr), .txn_write(txn_write), .txn_master(txn_master),
        .txn_fetch(txn_fetch), .txn_done(txn_done), .txn_abort(txn_abort),
        .sw_exception(sw_exception), .emu_trap(emu_trap),
        .emulation_indication_pin(emulation_indication_pin));
    bawp_bus_model far (.clk_sys(clk_sys), .req(req), .req_addr(req_addr),
        .req_write(req_write), .req_master(req_master), .req_fetch(req_fetch),
        .req_abort(req_abort), .txn_valid(txn_valid), .txn_addr(txn_addr),
        .txn_write(txn_write), .txn_master(txn_master), .txn_fetch(txn_fetch),
        .txn_done(txn_done), .txn_abort(txn_abort));

    function automatic logic [31:0] ad(int s, logic [7:0] o);
        return 32'(s) * 32'(BAWP_SET_STRIDE) + 32'(o);
    endfunction
    function automatic logic [31:0] mk(logic [1:0] md, logic [5:0] m, logic r, logic w,
        logic [1:0] ac, logic cb, logic [15:0] n);
        return {n, 3'h0, cb, ac, w, r, m, md};
    endfunction
    function automatic logic [31:0] st(logic [1:0] ex, logic [15:0] n);
        return {14'h0, ex, n};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= BAWP_HTRANS_NONSEQ;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask
    task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        chk(nm, q, exp);
        chk("hresp", {30'h0, hresp}, {30'h0, BAWP_HRESP_OKAY});
    endtask
    // exp holds the expected {sw_exception, emu_trap, emulation_indication_pin}
    task automatic send(input logic [31:0] a, input logic w, input logic [2:0] m,
        input logic f, input logic ab, input logic [2:0] exp);
        @(posedge clk_sys);
        req <= 1'b1;
        req_addr <= a;
        req_write <= w;
        req_master <= m;
        req_fetch <= f;
        req_abort <= ab;
        @(posedge clk_sys);
        req <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk("pulses", {29'h0, sw_exception, emu_trap, emulation_indication_pin}, {29'h0, exp});
    endtask
    task automatic setup(input int s, input logic [31:0] lo, input logic [31:0] hi,
        input logic [31:0] c);
        wr(ad(s, BAWP_OFS_CTL), 32'h0);
        wr(ad(s, BAWP_OFS_LOW), lo);
        wr(ad(s, BAWP_OFS_HIGH), hi);
        wr(ad(s, BAWP_OFS_CTL), c);
    endtask

    task automatic t_reset();
        rc("ctl0", ad(0, BAWP_OFS_CTL), BAWP_RST_WORD);
        rc("stat2", ad(2, BAWP_OFS_STAT), BAWP_RST_WORD);
        wr(32'h0000_0030, 32'hFFFF_FFFF);
        rc("unmapped", 32'h0000_0030, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_single();
        logic [31:0] c;
        c = mk(BAWP_MODE_SINGLE, M_SEQ, 1'b1, 1'b0, BAWP_ACT_SWEXC, 1'b0, 16'h0002);
        setup(0, 32'h0000_0040, 32'h0000_0080, c);
        rc("ctl0", ad(0, BAWP_OFS_CTL), c);
        rc("stat0", ad(0, BAWP_OFS_STAT), st(BAWP_EXEC_SEARCH, 16'h0002));
        send(32'h0000_0080, 1'b0, BAWP_MST_SEQ, 1'b0, 1'b0, 3'h0);
        send(32'h0000_0040, 1'b0, BAWP_MST_SEQ, 1'b0, 1'b0, 3'h0);
        send(32'h0000_0040, 1'b0, BAWP_MST_SEQ, 1'b0, 1'b0, 3'h4);
        rc("stat0", ad(0, BAWP_OFS_STAT), st(BAWP_EXEC_EXPIRED, 16'h0));
        send(32'h0000_0040, 1'b0, BAWP_MST_SEQ, 1'b0, 1'b0, 3'h0);
        $display("single test done");
    endtask
    task automatic t_range();
        setup(1, 32'h0002_0100, 32'h0002_01FF,
            mk(BAWP_MODE_RANGE, M_J, 1'b0, 1'b1, BAWP_ACT_TRAP, 1'b0, 16'h0001));
        send(32'h0002_0180, 1'b0, BAWP_MST_JIALU, 1'b0, 1'b0, 3'h0);
        send(32'h0002_0180, 1'b1, BAWP_MST_KIALU, 1'b0, 1'b0, 3'h0);
        send(32'h0002_0180, 1'b1, BAWP_MST_JIALU, 1'b0, 1'b1, 3'h0);
        send(32'h0002_00FF, 1'b1, BAWP_MST_JIALU, 1'b0, 1'b0, 3'h0);
        send(32'h0002_01FF, 1'b1, BAWP_MST_JIALU, 1'b0, 1'b0, 3'h2);
        setup(2, 32'h0003_0100, 32'h0003_0200,
            mk(BAWP_MODE_OUTSIDE, M_DMA, 1'b1, 1'b0, BAWP_ACT_PIN, 1'b0, 16'h0001));
        send(32'h0003_0150, 1'b0, BAWP_MST_DMA, 1'b0, 1'b0, 3'h0);
        send(32'h0003_0300, 1'b1, BAWP_MST_DMA, 1'b0, 1'b0, 3'h0);
        send(32'h0003_0300, 1'b0, BAWP_MST_DMA, 1'b0, 1'b0, 3'h1);
        $display("range test done");
    endtask
    task automatic t_ext();
        setup(0, 32'h1000_0000, 32'h1000_00FF,
            mk(BAWP_MODE_RANGE, M_DMA | M_HOST, 1'b1, 1'b1, BAWP_ACT_PIN, 1'b0, 16'h0001));
        send(32'h1000_0010, 1'b0, BAWP_MST_DMA, 1'b0, 1'b0, 3'h0);
        rc("stat0", ad(0, BAWP_OFS_STAT), st(BAWP_EXEC_SEARCH, 16'h0001));
        send(32'h1000_0010, 1'b0, BAWP_MST_HOST, 1'b0, 1'b0, 3'h1);
        setup(0, 32'h0000_0000, 32'h1000_0000,
            mk(BAWP_MODE_RANGE, M_SEQ, 1'b1, 1'b0, BAWP_ACT_TRAP, 1'b0, 16'h0001));
        send(32'h0005_0000, 1'b0, BAWP_MST_SEQ, 1'b1, 1'b0, 3'h2);
        $display("external test done");
    endtask
    task automatic t_comb();
        logic [31:0] c;
        c = mk(BAWP_MODE_SINGLE, M_SEQ, 1'b1, 1'b0, BAWP_ACT_PIN, 1'b1, 16'h0005);
        for (int s = 0; s < BAWP_SETS; s++) begin
            setup(s, (s == 2) ? 32'h0000_0200 : 32'h0000_0100, 32'h0, c);
        end
        send(32'h0000_0200, 1'b0, BAWP_MST_SEQ, 1'b0, 1'b0, 3'h0);
        rc("stat1", ad(1, BAWP_OFS_STAT), st(BAWP_EXEC_SEARCH, 16'h0004));
        rc("stat2", ad(2, BAWP_OFS_STAT), st(BAWP_EXEC_SEARCH, 16'h0005));
        rc("stat0", ad(0, BAWP_OFS_STAT), st(BAWP_EXEC_SEARCH, 16'h0004));
        setup(2, 32'h0000_0100, 32'h0, c);
        send(32'h0000_0100, 1'b0, BAWP_MST_SEQ, 1'b0, 1'b0, 3'h0);
        rc("stat1", ad(1, BAWP_OFS_STAT), st(BAWP_EXEC_SEARCH, 16'h0003));
        rc("stat2", ad(2, BAWP_OFS_STAT), st(BAWP_EXEC_SEARCH, 16'h0004));
        rc("stat0", ad(0, BAWP_OFS_STAT), st(BAWP_EXEC_SEARCH, 16'h0003));
        $display("combine test done");
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            stop_test();
        end
    end
    initial begin
        {rst_n, hsel, hwrite, req, req_write, req_fetch, req_abort} = 7'h0;
        {haddr, hwdata, req_addr} = 96'h0;
        htrans = 2'h0;
        req_master = 3'h0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_single();
        t_range();
        t_ext();
        t_comb();
        stop_test();
    end
endmodule
`default_nettype wire
